// [rtl/jog_updown_map.svh]
/*
 Offsets, field positions, reset values and function codes of the
 jog and up-down frequency command block. Assumes inclusion by bare name.
*/
`ifndef JOG_UPDOWN_MAP_SVH
`define JOG_UPDOWN_MAP_SVH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_JOG_FREQ 12'h004
`define REG_START_FREQ 12'h008
`define REG_MAX_FREQ 12'h00c
`define REG_FUNC_CODES 12'h010
`define REG_SAVED_FREQ 12'h014
`define REG_BASE_FREQ 12'h018
`define REG_STATUS 12'h01c
`define REG_CMD_FREQ 12'h020
`define REG_UPDOWN_FREQ 12'h024

// Control fields
`define CTRL_SAVE_BIT 0
`define CTRL_DWELL_BIT 1
`define CTRL_SRC_LSB 8
`define CTRL_SRC_MSB 11
`define CTRL_RUN_BIT 12
`define CTRL_DECEL_BIT 13

// Reset values, frequencies in 0.01 Hz
`define JOG_FREQ_RST 16'h03e8
`define START_FREQ_RST 16'h0032
`define MAX_FREQ_RST 16'h1770
`define FUNC_CODES_RST 40'h0403020100
`define FREQ_SRC_RST 4'h0

// Function codes and source select
`define FC_JOG 5'h04
`define FC_UP 5'h0f
`define FC_DOWN 5'h10
`define FC_JOG_FWD 5'h18
`define FC_SAVE_CLR 5'h19
`define SRC_UPDOWN 4'ha

// Terminal function code fields
`define FC_STRIDE 8
`define FC_WIDTH 5

// Status fields
`define STATUS_MODE_LSB 0
`define STATUS_MODE_MSB 2
`define STATUS_FC4_LSB 8
`define STATUS_FC4_MSB 15

// Bus byte lanes
`define BUS_LANES 4
`define LANE_BITS 8

// Up-down ramp step per enable tick
`define UD_STEP 16'h0001
`define UD_DIV 16'h4e1f

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/jog_updown_pkg.sv]
/*
 Types of the jog and up-down frequency command block.
 Assumes nothing of its surroundings.
*/
package jog_updown_pkg;

  typedef enum logic [2:0] {
    MODE_BASE = 3'b001,
    MODE_UPDOWN = 3'b010,
    MODE_JOG = 3'b100
  } mode_t;

  typedef struct packed {
    logic aw_busy;
    logic w_busy;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_state_t;

  typedef struct packed {
    logic save_opt;
    logic dwell;
    logic [3:0] freq_src;
    logic run;
    logic decel;
    logic [15:0] jog_freq;
    logic [15:0] start_freq;
    logic [15:0] max_freq;
    logic [39:0] func_codes;
    logic [15:0] saved_freq;
    logic [15:0] base_freq;
    logic [15:0] ud_freq;
    logic [15:0] cmd_freq;
    logic [15:0] div_cnt;
    logic run_prev;
    mode_t mode;
    mode_t prev_mode;
  } core_state_t;

endpackage

// [rtl/jog_updown_freq_command.sv]
/*
 Frequency command selection: jog, forward jog, up-down with save/clear,
 configured over an AXI4-Lite slave. Assumes terminal inputs synchronous
 to aclk and frequencies in units of 0.01 Hz.
*/
// What this block does
// - Jog frequency default 10.00 Hz, used during jog
// - Jog frequency clamped between start and maximum
// - Function code 4 selects jog input
// - Jog ranks second, only dwell above
// - Jog overrides multi-step, up-down, 3-wire command
// - Function code 24 selects forward jog input
// - Three terminals standard, five advanced, own codes
// - Up-down path only when source equals 10
// - Code 15 is up, code 16 is down
// - Code 25 clears saved up-down frequency
// - Save option 1 stores frequency before stop
// - Save option 0 stores nothing
// - Clear input clears saved frequency in up-down
// - Clear ignored while up or down asserted
`include "jog_updown_map.svh"

module jog_updown_freq_command
  import jog_updown_pkg::*;
#(
  parameter int NUM_INPUTS = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Multi-function input terminals
  input wire logic [NUM_INPUTS-1:0] multi_input,
  // Frequency command
  output logic [15:0] cmd_freq,
  output logic jog_active,
  output logic updown_active
);

  bus_state_t bus_q;
  bus_state_t bus_d;
  core_state_t core_q;
  core_state_t core_d;

  logic [NUM_INPUTS-1:0] is_jog;
  logic [NUM_INPUTS-1:0] is_up;
  logic [NUM_INPUTS-1:0] is_down;
  logic [NUM_INPUTS-1:0] is_clr;
  logic jog_req;
  logic up_req;
  logic down_req;
  logic clr_req;
  logic updown_en;
  logic [15:0] jog_lim;
  logic tick;
  logic do_write;
  logic stop_edge;
  logic [31:0] rd_val;
  logic rd_err;
  logic [31:0] wmask;
  mode_t sel_mode;
  logic wr_ok;
  logic save_now;
  logic clr_ok;
  logic ramp_up;
  logic ramp_down;
  logic enter_ud;

  // Per-terminal function decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_term
      logic [4:0] fc;
      assign fc = core_q.func_codes[gi*`FC_STRIDE +: `FC_WIDTH];
      assign is_jog[gi] = multi_input[gi] && (fc == `FC_JOG || fc == `FC_JOG_FWD);
      assign is_up[gi] = multi_input[gi] && (fc == `FC_UP);
      assign is_down[gi] = multi_input[gi] && (fc == `FC_DOWN);
      assign is_clr[gi] = multi_input[gi] && (fc == `FC_SAVE_CLR);
    end
  endgenerate

  assign jog_req = |is_jog;
  assign up_req = |is_up;
  assign down_req = |is_down;
  assign clr_req = |is_clr;
  assign updown_en = (core_q.freq_src == `SRC_UPDOWN);

  // Jog frequency clamp
  always_comb begin
    if (core_q.jog_freq < core_q.start_freq) begin
      jog_lim = core_q.start_freq;
    end else if (core_q.jog_freq > core_q.max_freq) begin
      jog_lim = core_q.max_freq;
    end else begin
      jog_lim = core_q.jog_freq;
    end
  end

  // Mode selection, dwell above jog
  always_comb begin
    if (core_q.dwell) begin
      sel_mode = core_q.prev_mode;
    end else if (jog_req) begin
      sel_mode = MODE_JOG;
    end else if (updown_en) begin
      sel_mode = MODE_UPDOWN;
    end else begin
      sel_mode = MODE_BASE;
    end
  end

  assign tick = (core_q.div_cnt == `UD_DIV);
  assign stop_edge = (core_q.run_prev && !core_q.run) || core_q.decel;

  // Save, clear and ramp qualifiers
  assign save_now = updown_en && core_q.save_opt && stop_edge;
  assign clr_ok = updown_en && clr_req && !up_req && !down_req;
  assign ramp_up = updown_en && tick && up_req && !down_req &&
                   (core_q.ud_freq < core_q.max_freq);
  assign ramp_down = updown_en && tick && down_req && !up_req &&
                     (core_q.ud_freq > core_q.start_freq);
  assign enter_ud = (core_q.mode == MODE_BASE) && (sel_mode == MODE_UPDOWN) &&
                    core_q.save_opt;

  // Bus write strobe mask, one byte lane each
  genvar gb;
  generate
    for (gb = 0; gb < `BUS_LANES; gb++) begin : g_lane
      assign wmask[gb*`LANE_BITS +: `LANE_BITS] = {`LANE_BITS{bus_q.wstrb[gb]}};
    end
  endgenerate

  assign do_write = bus_q.aw_busy && bus_q.w_busy && !bus_q.bvalid;

  // Write decode, read-only and unmapped words refused
  always_comb begin
    wr_ok = 1'b0;
    if (bus_q.awaddr == `REG_CTRL) begin
      wr_ok = 1'b1;
    end else if (bus_q.awaddr == `REG_JOG_FREQ) begin
      wr_ok = 1'b1;
    end else if (bus_q.awaddr == `REG_START_FREQ) begin
      wr_ok = 1'b1;
    end else if (bus_q.awaddr == `REG_MAX_FREQ) begin
      wr_ok = 1'b1;
    end else if (bus_q.awaddr == `REG_FUNC_CODES) begin
      wr_ok = 1'b1;
    end else if (bus_q.awaddr == `REG_SAVED_FREQ) begin
      wr_ok = 1'b1;
    end else if (bus_q.awaddr == `REG_BASE_FREQ) begin
      wr_ok = 1'b1;
    end else if (bus_q.awaddr == `REG_STATUS) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_axi_araddr == `REG_CTRL) begin
      rd_val[`CTRL_SAVE_BIT] = core_q.save_opt;
      rd_val[`CTRL_DWELL_BIT] = core_q.dwell;
      rd_val[`CTRL_SRC_MSB:`CTRL_SRC_LSB] = core_q.freq_src;
      rd_val[`CTRL_RUN_BIT] = core_q.run;
      rd_val[`CTRL_DECEL_BIT] = core_q.decel;
    end else if (s_axi_araddr == `REG_JOG_FREQ) begin
      rd_val[15:0] = core_q.jog_freq;
    end else if (s_axi_araddr == `REG_START_FREQ) begin
      rd_val[15:0] = core_q.start_freq;
    end else if (s_axi_araddr == `REG_MAX_FREQ) begin
      rd_val[15:0] = core_q.max_freq;
    end else if (s_axi_araddr == `REG_FUNC_CODES) begin
      rd_val = core_q.func_codes[31:0];
    end else if (s_axi_araddr == `REG_SAVED_FREQ) begin
      rd_val[15:0] = core_q.saved_freq;
    end else if (s_axi_araddr == `REG_BASE_FREQ) begin
      rd_val[15:0] = core_q.base_freq;
    end else if (s_axi_araddr == `REG_STATUS) begin
      rd_val[`STATUS_MODE_MSB:`STATUS_MODE_LSB] = core_q.mode;
      rd_val[`STATUS_FC4_MSB:`STATUS_FC4_LSB] = core_q.func_codes[39:32];
    end else if (s_axi_araddr == `REG_CMD_FREQ) begin
      rd_val[15:0] = core_q.cmd_freq;
    end else if (s_axi_araddr == `REG_UPDOWN_FREQ) begin
      rd_val[15:0] = core_q.ud_freq;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Bus next state
  always_comb begin
    bus_d = bus_q;
    if (!bus_q.aw_busy && s_axi_awvalid) begin
      bus_d.aw_busy = 1'b1;
      bus_d.awaddr = s_axi_awaddr;
    end
    if (!bus_q.w_busy && s_axi_wvalid) begin
      bus_d.w_busy = 1'b1;
      bus_d.wdata = s_axi_wdata;
      bus_d.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      bus_d.bvalid = 1'b1;
      bus_d.bresp = `RESP_OKAY;
      if (!wr_ok) begin
        bus_d.bresp = `RESP_SLVERR;
      end
    end
    if (bus_q.bvalid && s_axi_bready) begin
      bus_d.bvalid = 1'b0;
      bus_d.aw_busy = 1'b0;
      bus_d.w_busy = 1'b0;
    end
    if (!bus_q.rvalid && s_axi_arvalid) begin
      bus_d.rvalid = 1'b1;
      bus_d.rdata = rd_val;
      bus_d.rresp = rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bus_q.rvalid && s_axi_rready) begin
      bus_d.rvalid = 1'b0;
    end
  end

  // Core next state
  always_comb begin
    core_d = core_q;
    core_d.run_prev = core_q.run;
    core_d.div_cnt = tick ? 16'h0000 : core_q.div_cnt + 16'h0001;
    if (do_write) begin
      if (bus_q.awaddr == `REG_CTRL) begin
        core_d.save_opt = wmask[`CTRL_SAVE_BIT] ? bus_q.wdata[`CTRL_SAVE_BIT] : core_q.save_opt;
        core_d.dwell = wmask[`CTRL_DWELL_BIT] ? bus_q.wdata[`CTRL_DWELL_BIT] : core_q.dwell;
        core_d.freq_src = wmask[`CTRL_SRC_LSB] ?
                          bus_q.wdata[`CTRL_SRC_MSB:`CTRL_SRC_LSB] : core_q.freq_src;
        core_d.run = wmask[`CTRL_RUN_BIT] ? bus_q.wdata[`CTRL_RUN_BIT] : core_q.run;
        core_d.decel = wmask[`CTRL_DECEL_BIT] ? bus_q.wdata[`CTRL_DECEL_BIT] : core_q.decel;
      end else if (bus_q.awaddr == `REG_JOG_FREQ) begin
        core_d.jog_freq = (bus_q.wdata[15:0] & wmask[15:0]) | (core_q.jog_freq & ~wmask[15:0]);
      end else if (bus_q.awaddr == `REG_START_FREQ) begin
        core_d.start_freq = (bus_q.wdata[15:0] & wmask[15:0]) |
                            (core_q.start_freq & ~wmask[15:0]);
      end else if (bus_q.awaddr == `REG_MAX_FREQ) begin
        core_d.max_freq = (bus_q.wdata[15:0] & wmask[15:0]) | (core_q.max_freq & ~wmask[15:0]);
      end else if (bus_q.awaddr == `REG_FUNC_CODES) begin
        core_d.func_codes[31:0] = (bus_q.wdata & wmask) | (core_q.func_codes[31:0] & ~wmask);
      end else if (bus_q.awaddr == `REG_STATUS) begin
        if (wmask[`STATUS_FC4_LSB]) begin
          core_d.func_codes[39:32] = bus_q.wdata[`STATUS_FC4_MSB:`STATUS_FC4_LSB];
        end
      end else if (bus_q.awaddr == `REG_SAVED_FREQ) begin
        core_d.saved_freq = (bus_q.wdata[15:0] & wmask[15:0]) |
                            (core_q.saved_freq & ~wmask[15:0]);
      end else if (bus_q.awaddr == `REG_BASE_FREQ) begin
        core_d.base_freq = (bus_q.wdata[15:0] & wmask[15:0]) |
                           (core_q.base_freq & ~wmask[15:0]);
      end
    end

    // Up-down ramp
    if (ramp_up) begin
      core_d.ud_freq = core_q.ud_freq + `UD_STEP;
    end else if (ramp_down) begin
      core_d.ud_freq = core_q.ud_freq - `UD_STEP;
    end

    // Save on stop or deceleration
    if (save_now) begin
      core_d.saved_freq = core_q.ud_freq;
    end

    // Clear saved value, blocked by up or down
    if (clr_ok) begin
      core_d.saved_freq = 16'h0000;
      core_d.ud_freq = 16'h0000;
    end

    // Mode tracking for return after jog
    core_d.mode = sel_mode;
    if (sel_mode != MODE_JOG && core_q.mode != MODE_JOG) begin
      core_d.prev_mode = sel_mode;
    end
    if (core_q.mode == MODE_JOG && sel_mode != MODE_JOG && updown_en) begin
      core_d.mode = core_q.prev_mode == MODE_UPDOWN ? MODE_UPDOWN : sel_mode;
    end
    if (enter_ud) begin
      core_d.ud_freq = core_q.saved_freq;
    end
    case (core_d.mode)
      MODE_JOG: core_d.cmd_freq = jog_lim;
      MODE_UPDOWN: core_d.cmd_freq = core_d.ud_freq;
      default: core_d.cmd_freq = core_q.base_freq;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_q <= '0;
      core_q <= '0;
      core_q.jog_freq <= `JOG_FREQ_RST;
      core_q.start_freq <= `START_FREQ_RST;
      core_q.max_freq <= `MAX_FREQ_RST;
      core_q.func_codes <= `FUNC_CODES_RST;
      core_q.freq_src <= `FREQ_SRC_RST;
      core_q.mode <= MODE_BASE;
      core_q.prev_mode <= MODE_BASE;
    end else begin
      bus_q <= bus_d;
      core_q <= core_d;
    end
  end

  assign s_axi_awready = !bus_q.aw_busy;
  assign s_axi_wready = !bus_q.w_busy;
  assign s_axi_bvalid = bus_q.bvalid;
  assign s_axi_bresp = bus_q.bresp;
  assign s_axi_arready = !bus_q.rvalid;
  assign s_axi_rvalid = bus_q.rvalid;
  assign s_axi_rdata = bus_q.rdata;
  assign s_axi_rresp = bus_q.rresp;
  assign cmd_freq = core_q.cmd_freq;
  assign jog_active = (core_q.mode == MODE_JOG);
  assign updown_active = (core_q.mode == MODE_UPDOWN);

endmodule

// [verification/terminal_switches.sv]
/*
 Switch model for the multi-function input terminals.
 Assumes the bench sets press just after a rising edge of aclk.
*/
module terminal_switches (
  // Clock
  input wire logic aclk,
  // Wanted switch levels
  input wire logic [4:0] press,
  // Terminal levels
  output logic [4:0] multi_input
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts settle one clock later
  always_ff @(posedge aclk) begin
    multi_input <= press;
  end
endmodule

// [verification/jog_updown_props.sv]
/*
 Bus and mode checks of the frequency command block.
 Assumes binding to the block's top module.
*/
module jog_updown_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Command
  input wire logic [15:0] cmd_freq,
  input wire logic jog_active,
  input wire logic updown_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_mode_excl;
    !(jog_active && updown_active);
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("jog and up-down both active");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken while answering");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read answer kept");
  property p_reset_cmd;
    $rose(aresetn) |-> cmd_freq == 16'h0000 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("state after reset wrong");
endmodule
bind jog_updown_freq_command jog_updown_props chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .cmd_freq, .jog_active, .updown_active);

// [verification/testbench.sv]
/*
 Self-checking bench of the frequency command block.
 Assumes the design files and the switch model are compiled first.
*/
`include "jog_updown_map.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, u;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] cmd_freq;
  logic jog_active, updown_active;
  logic [4:0] press = 0, multi_input;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  jog_updown_freq_command uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .multi_input, .cmd_freq, .jog_active, .updown_active);
  terminal_switches sw (.aclk, .press, .multi_input);
  initial forever #25 aclk = ~aclk;
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
    logic ta, tw;
    ta = 0;
    tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || s_axi_awready;
      tw = tw || s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", e, s_axi_bresp)
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_reset;
    rd(`REG_JOG_FREQ, d);
    `CHK("jog", `JOG_FREQ_RST, d[15:0])
    rd(`REG_START_FREQ, d);
    `CHK("start", `START_FREQ_RST, d[15:0])
    rd(`REG_MAX_FREQ, d);
    `CHK("max", `MAX_FREQ_RST, d[15:0])
    rd(`REG_FUNC_CODES, d);
    `CHK("codes", 32'h03020100, d)
    rd(`REG_STATUS, d);
    `CHK("code4", `FC_JOG, d[12:8])
    `CHK("mode", 3'h1, d[2:0])
    $display("test reset done");
  endtask
  task automatic t_jog;
    wr(`REG_BASE_FREQ, 32'h07d0, `RESP_OKAY);
    press <= 5'h10;
    wt(4);
    `CHK("jog on", 1'b1, jog_active)
    `CHK("cmd", `JOG_FREQ_RST, cmd_freq)
    `CHK("ud off", 1'b0, updown_active)
    rd(`REG_STATUS, d);
    `CHK("jog mode", 3'h4, d[2:0])
    rd(`REG_CMD_FREQ, d);
    `CHK("cmd rd", `JOG_FREQ_RST, d[15:0])
    press <= 5'h00;
    wt(4);
    `CHK("back", 16'h07d0, cmd_freq)
    wr(`REG_CTRL, 32'h0002, `RESP_OKAY);
    press <= 5'h10;
    wt(4);
    `CHK("dwell", 1'b0, jog_active)
    `CHK("dwell cmd", 16'h07d0, cmd_freq)
    press <= 5'h00;
    wr(`REG_CTRL, 32'h0000, `RESP_OKAY);
    wr(`REG_FUNC_CODES, 32'h03020118, `RESP_OKAY);
    press <= 5'h01;
    wt(4);
    `CHK("fwd jog", 1'b1, jog_active)
    press <= 5'h00;
    wt(4);
    `CHK("fwd off", 1'b0, jog_active)
    $display("test jog done");
  endtask
  task automatic t_updown;
    wr(`REG_FUNC_CODES, 32'h19100f18, `RESP_OKAY);
    wr(`REG_CTRL, 32'h1a00, `RESP_OKAY);
    wt(4);
    `CHK("ud on", 1'b1, updown_active)
    press <= 5'h10;
    wt(4);
    `CHK("ud jog", 1'b1, jog_active)
    `CHK("ud jog cmd", `JOG_FREQ_RST, cmd_freq)
    press <= 5'h02;
    wt(45000);
    press <= 5'h00;
    wt(4);
    rd(`REG_UPDOWN_FREQ, u);
    `CHK("ramp", 1'b1, u[15:0] >= 16'h0002 && u[15:0] <= 16'h0003)
    wr(`REG_CTRL, 32'h0a00, `RESP_OKAY);
    rd(`REG_SAVED_FREQ, d);
    `CHK("no save", 16'h0, d[15:0])
    wr(`REG_CTRL, 32'h1a01, `RESP_OKAY);
    rd(`REG_UPDOWN_FREQ, u);
    wr(`REG_CTRL, 32'h0a01, `RESP_OKAY);
    rd(`REG_SAVED_FREQ, d);
    `CHK("save", u[15:0], d[15:0])
    wr(`REG_SAVED_FREQ, 32'h0, `RESP_OKAY);
    rd(`REG_SAVED_FREQ, d);
    `CHK("saved wr", 16'h0, d[15:0])
    wr(`REG_CTRL, 32'h2a01, `RESP_OKAY);
    rd(`REG_SAVED_FREQ, d);
    `CHK("decel save", u[15:0], d[15:0])
    wr(`REG_CTRL, 32'h0a01, `RESP_OKAY);
    press <= 5'h0a;
    wt(4);
    rd(`REG_SAVED_FREQ, d);
    `CHK("clr blocked", u[15:0], d[15:0])
    press <= 5'h0c;
    wt(4);
    rd(`REG_SAVED_FREQ, d);
    `CHK("clr blocked dn", u[15:0], d[15:0])
    press <= 5'h08;
    wt(4);
    rd(`REG_SAVED_FREQ, d);
    `CHK("clr", 16'h0, d[15:0])
    press <= 5'h00;
    $display("test updown done");
  endtask
  task automatic t_clamp;
    wr(`REG_JOG_FREQ, 32'h000a, `RESP_OKAY);
    press <= 5'h10;
    wt(4);
    `CHK("low", `START_FREQ_RST, cmd_freq)
    wr(`REG_JOG_FREQ, 32'h2328, `RESP_OKAY);
    wt(4);
    `CHK("high", `MAX_FREQ_RST, cmd_freq)
    press <= 5'h00;
    wr(12'h040, 32'h1, `RESP_SLVERR);
    wr(`REG_CMD_FREQ, 32'h1, `RESP_SLVERR);
    rd(12'h040, d);
    `CHK("rresp", `RESP_SLVERR, r)
    `CHK("rdata", 32'h0, d)
    $display("test clamp and bus done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_jog;
    t_updown;
    t_clamp;
    complete_run;
  end
endmodule
